// ==== hw/paging_port.sv ====
// Device end of the backplane block-paging exchange, with its database.
// Assumes the processor keeps its half of the exchange and that the command
// queue outside reports its free slots on cmd_free.
//
// Chosen here: the APB interface to the registers and the placing of the registers.
`timescale 1ns/1ps
// Overview of operation
// - Module drives the eight-word input image; processor drives the seven-word one.
// - Every data transfer moves exactly six words; a code picks a page.
// - Input word 0 carries the written page code, word 1 the requested one.
// - Codes run 1 to 666 for data; code zero carries nothing and is ignored.
// - Code one is the first six-word page, each next code the next page.
// - A new block is seen when word 0 differs from the stored last code.
// - At start both page codes are one and the last-read code is zero.
// - Six words go to words 2 to 7, read code to word 1, word 0 last.
// - New data code stores words 1 to 6 at read base plus page offset.
// - After a read, pick next pages, load them and trigger again, forever.
// - Configuration sets read and write bases and register counts.
// - Codes 1000 to 1255 request one command to slave code minus 1000.
// - Codes 2001 to 2006 queue listed commands, count is code minus 2000 or cmd_free, whichever is less.
// - Code 9998 warm restarts working values from the stored configuration.
// - Code 9999 restarts configuration and paging state; the database keeps its contents.
module paging_port
  import paging_pkg::*;
(
  // Clock and reset
  input  wire logic                        clk,
  input  wire logic                        rst_b,
  // APB register bus
  input  wire logic                        psel,
  input  wire logic                        penable,
  input  wire logic                        pwrite,
  input  wire logic [7:0]                  paddr,
  input  wire logic [31:0]                 pwdata,
  output logic      [31:0]                 prdata,
  output logic                             pready,
  output logic                             pslverr,
  // Backplane images
  output logic      [IN_WORDS-1:0][15:0]   in_img,
  input  wire logic [OUT_WORDS-1:0][15:0]  out_img,
  // Command requests
  input  wire logic [3:0]                  cmd_free,
  output logic                             ev_valid,
  output logic      [7:0]                  ev_slave,
  output logic                             q_valid,
  output logic      [2:0]                  q_count,
  output logic      [PAGE_WORDS-1:0][15:0] cmd_word,
  output logic                             cold_restart
);
  // ==========================================================================
  // Working state
  page_state_e state;
  logic [15:0] rd_base;
  logic [15:0] wr_base;
  logic [15:0] rd_count;
  logic [15:0] wr_count;
  logic [15:0] wr_code;
  logic [15:0] rd_code;
  logic [15:0] last_read;
  logic [15:0] cur_code;
  logic [15:0] head_code;
  logic [15:0] pages_sent;
  logic [15:0] db_ptr;
  logic [2:0]  idx;
  logic [15:0] wr_pages;
  logic [15:0] rd_pages;
  logic [15:0] src_addr;
  logic [15:0] dst_addr;
  logic [15:0] src_data;
  logic [15:0] apb_data;
  logic [3:0]  q_acc;
  logic        new_blk;
  logic        is_data;
  logic        is_ev;
  logic        is_q;
  logic        is_ctl;
  logic        fsm_we;
  logic        apb_we;
  logic        apb_rd_ph;
  logic        apb_acc;
  logic        mapped;

  // Pages needed to cover a register count, at least one, at most 666.
  function automatic logic [15:0] page_count(input logic [15:0] regs);
    logic [16:0] p;
    p = (17'(regs) + 17'(PAGE_WORDS - 1)) / 17'(PAGE_WORDS);
    if (p == 17'd0)
      p = 17'(CODE_FIRST);
    if (p > 17'(CODE_DATA_MAX))
      p = 17'(CODE_DATA_MAX);
    return p[15:0];
  endfunction

  assign wr_pages = page_count(wr_count);
  assign rd_pages = page_count(rd_count);
  // Page offsets: code one is the first page.
  assign src_addr = 16'(wr_base + (wr_code - CODE_FIRST) * 16'(PAGE_WORDS)
                        + 16'(idx));
  assign dst_addr = 16'(rd_base + (cur_code - CODE_FIRST) * 16'(PAGE_WORDS)
                        + 16'(idx));
  assign new_blk  = (state == ST_WAIT) && (out_img[0] != last_read);
  assign is_data  = (out_img[0] >= CODE_FIRST) && (out_img[0] <= CODE_DATA_MAX);
  assign is_ev    = (out_img[0] >= CODE_EV_LO) && (out_img[0] <= CODE_EV_HI);
  assign is_q     = (out_img[0] >= CODE_Q_LO) && (out_img[0] <= CODE_Q_HI);
  assign is_ctl   = is_ev || is_q || (out_img[0] == CODE_WARM)
                    || (out_img[0] == CODE_COLD);
  assign fsm_we   = (state == ST_STORE) && (dst_addr < 16'(DB_DEPTH));
  assign q_acc    = (4'(cur_code - CODE_Q_BASE) < cmd_free)
                    ? 4'(cur_code - CODE_Q_BASE) : cmd_free;

  // ==========================================================================
  // Database
  word_store #(.W(16), .DEPTH(DB_DEPTH), .AW(DB_AW)) u_db (
    .clk     (clk),
    .rst_b   (rst_b),
    .we      (fsm_we || apb_we),
    .waddr   (fsm_we ? dst_addr[DB_AW-1:0] : db_ptr[DB_AW-1:0]),
    .wdata   (fsm_we ? out_img[3'(idx) + 3'd1] : pwdata[15:0]),
    .raddr_a (src_addr[DB_AW-1:0]),
    .rdata_a (src_data),
    .raddr_b (db_ptr[DB_AW-1:0]),
    .rdata_b (apb_data)
  );

  // ==========================================================================
  // APB slave
  assign apb_rd_ph = psel && !penable;
  assign mapped    = (paddr <= OFS_DB_DATA) && (paddr[1:0] == 2'b00);
  // A database write waits while paging owns the write port.
  assign pready    = !(psel && penable && pwrite && (paddr == OFS_DB_DATA)
                       && (state == ST_STORE));
  assign apb_acc   = psel && penable && pready;
  assign apb_we    = apb_acc && pwrite && (paddr == OFS_DB_DATA)
                     && (db_ptr < 16'(DB_DEPTH));
  assign pslverr   = psel && penable && !mapped;

  always_ff @(posedge clk)
  begin
    if (!rst_b)
      prdata <= 32'h0000_0000;
    else if (apb_rd_ph && !pwrite)
    begin
      case (paddr)
        OFS_RD_BASE:  prdata <= {16'h0000, rd_base};
        OFS_WR_BASE:  prdata <= {16'h0000, wr_base};
        OFS_RD_COUNT: prdata <= {16'h0000, rd_count};
        OFS_WR_COUNT: prdata <= {16'h0000, wr_count};
        OFS_CODES:    prdata <= {rd_code, wr_code};
        OFS_LAST:     prdata <= {16'h0000, last_read};
        OFS_PAGES:    prdata <= {16'h0000, pages_sent};
        OFS_DB_ADDR:  prdata <= {16'h0000, db_ptr};
        OFS_DB_DATA:  prdata <= {16'h0000, apb_data};
        default:      prdata <= 32'h0000_0000;
      endcase
    end
  end

  // Configuration survives a warm restart; a cold restart reloads defaults.
  always_ff @(posedge clk)
  begin
    if (!rst_b || cold_restart)
    begin
      rd_base  <= RST_RD_BASE;
      wr_base  <= RST_WR_BASE;
      rd_count <= RST_RD_COUNT;
      wr_count <= RST_WR_COUNT;
      db_ptr   <= 16'h0000;
    end
    else if (apb_acc && pwrite)
    begin
      case (paddr)
        OFS_RD_BASE:  rd_base  <= pwdata[15:0];
        OFS_WR_BASE:  wr_base  <= pwdata[15:0];
        OFS_RD_COUNT: rd_count <= pwdata[15:0];
        OFS_WR_COUNT: wr_count <= pwdata[15:0];
        OFS_DB_ADDR:  db_ptr   <= pwdata[15:0];
        default:      db_ptr   <= db_ptr;
      endcase
    end
  end

  // ==========================================================================
  // Paging sequencer
  always_ff @(posedge clk)
  begin
    if (!rst_b || cold_restart)
    begin
      state      <= ST_LOAD;
      wr_code    <= CODE_FIRST;
      rd_code    <= CODE_FIRST;
      last_read  <= (!rst_b) ? CODE_NONE : CODE_COLD;
      cur_code   <= CODE_NONE;
      head_code  <= CODE_NONE;
      idx        <= 3'd0;
      pages_sent <= 16'h0000;
    end
    else
    begin
      case (state)
        ST_LOAD:
        begin
          idx <= (idx == 3'(PAGE_WORDS - 1)) ? 3'd0 : idx + 3'd1;
          if (idx == 3'(PAGE_WORDS - 1))
          begin
            head_code <= wr_code;
            state     <= ST_TRIG;
          end
        end
        ST_TRIG:
          state <= ST_HEAD;
        ST_HEAD:
        begin
          pages_sent <= pages_sent + 16'h0001;
          state      <= ST_WAIT;
        end
        ST_WAIT:
        begin
          if (new_blk)
          begin
            cur_code <= out_img[0];
            if (is_data)
              state <= ST_STORE;
            else if (is_ctl)
              state <= ST_CMD;
            else if (out_img[0] == CODE_NONE)
              last_read <= CODE_NONE;
            else
            begin
              last_read <= out_img[0];
              state     <= ST_NEXT;
            end
          end
        end
        ST_STORE:
        begin
          idx <= (idx == 3'(PAGE_WORDS - 1)) ? 3'd0 : idx + 3'd1;
          if (idx == 3'(PAGE_WORDS - 1))
          begin
            last_read <= cur_code;
            state     <= ST_NEXT;
          end
        end
        ST_NEXT:
        begin
          wr_code <= (wr_code >= wr_pages) ? CODE_FIRST : wr_code + 16'h0001;
          rd_code <= (rd_code >= rd_pages) ? CODE_FIRST : rd_code + 16'h0001;
          state   <= ST_LOAD;
        end
        ST_CMD:
        begin
          last_read <= cur_code;
          if (cur_code == CODE_WARM)
          begin
            wr_code <= CODE_FIRST;
            rd_code <= CODE_FIRST;
            state   <= ST_LOAD;
          end
          else
          begin
            head_code <= cur_code;
            state     <= ST_TRIG;
          end
        end
        default:
          state <= ST_LOAD;
      endcase
    end
  end

  // ==========================================================================
  // Input image: data words first, read request next, code word last.
  always_ff @(posedge clk)
  begin
    if (!rst_b)
      in_img <= '0;
    else
    begin
      case (state)
        ST_LOAD:
          in_img[3'(idx) + 3'd2] <= (src_addr < 16'(DB_DEPTH)) ? src_data : 16'h0000;
        ST_TRIG:
          in_img[1] <= rd_code;
        ST_HEAD:
          in_img[0] <= head_code;
        ST_CMD:
        begin
          for (int i = 2; i < IN_WORDS; i++)
            in_img[i] <= 16'h0000;
          if (cur_code <= CODE_EV_HI)
            in_img[2] <= {15'h0000, cmd_free != 4'd0};
          else
            in_img[2] <= {12'h000, q_acc};
        end
        default:
          in_img <= in_img;
      endcase
    end
  end

  // ==========================================================================
  // Command requests toward the queue
  always_ff @(posedge clk)
  begin
    if (!rst_b)
    begin
      ev_valid     <= 1'b0;
      ev_slave     <= 8'h00;
      q_valid      <= 1'b0;
      q_count      <= 3'd0;
      cmd_word     <= '0;
      cold_restart <= 1'b0;
    end
    else
    begin
      ev_valid     <= 1'b0;
      q_valid      <= 1'b0;
      cold_restart <= 1'b0;
      if (new_blk && is_ctl)
      begin
        for (int i = 0; i < PAGE_WORDS; i++)
          cmd_word[i] <= out_img[i + 1];
      end
      if (state == ST_CMD)
      begin
        if (cur_code >= CODE_EV_LO && cur_code <= CODE_EV_HI)
        begin
          ev_valid <= cmd_free != 4'd0;
          ev_slave <= 8'(cur_code - CODE_EV_LO);
        end
        if (cur_code >= CODE_Q_LO && cur_code <= CODE_Q_HI)
        begin
          q_valid <= q_acc != 4'd0;
          q_count <= 3'(q_acc);
        end
        cold_restart <= cur_code == CODE_COLD;
      end
    end
  end

  // ==========================================================================
  // Checks
  sequence seq_store_burst;
    (state == ST_STORE) [*6] ##1 (state == ST_NEXT);
  endsequence

  sequence seq_send_page;
    (state == ST_TRIG) ##1 (state == ST_HEAD) ##1 (state == ST_WAIT);
  endsequence

  chk_code_last: assert property (@(posedge clk) disable iff (!rst_b)
    (state == ST_LOAD && idx == 3'd5) |=> seq_send_page ##0 (in_img[0] == $past(wr_code, 3))
    ) else $error("code word not written last");

  chk_read_req: assert property (@(posedge clk) disable iff (!rst_b)
    (state == ST_TRIG) |=> (in_img[1] == $past(rd_code)) && (in_img[0] == $past(in_img[0]))
    ) else $error("read request word wrong");

  chk_store_six: assert property (@(posedge clk) disable iff (!rst_b)
    (new_blk && is_data) |=> seq_store_burst ##1 (last_read == $past(out_img[0], 8))
    ) else $error("data page not stored as six words");

  chk_no_change: assert property (@(posedge clk) disable iff (!rst_b)
    (state == ST_WAIT && out_img[0] == last_read) |=> (state == ST_WAIT)
    ) else $error("acted without a new code");

  chk_zero_ignored: assert property (@(posedge clk) disable iff (!rst_b)
    (new_blk && out_img[0] == CODE_NONE) |=> (state == ST_WAIT) && !ev_valid && !q_valid
    ) else $error("zero code not ignored");

  chk_event_req: assert property (@(posedge clk) disable iff (!rst_b)
    (new_blk && is_ev && cmd_free != 4'd0) |-> ##2 ev_valid
      && (ev_slave == 8'($past(out_img[0], 2) - CODE_EV_LO))
    ) else $error("event request slave address wrong");

  chk_queue_count: assert property (@(posedge clk) disable iff (!rst_b)
    (new_blk && is_q && cmd_free >= 4'd6) |-> ##2 q_valid
      && (q_count == 3'($past(out_img[0], 2) - CODE_Q_BASE))
    ) else $error("queue count wrong");

  chk_warm_codes: assert property (@(posedge clk) disable iff (!rst_b)
    (state == ST_CMD && cur_code == CODE_WARM) |=> (wr_code == CODE_FIRST)
      && (rd_code == CODE_FIRST) && (state == ST_LOAD) && (rd_base == $past(rd_base))
    ) else $error("warm restart did not reinitialise");

  chk_cold_pulse: assert property (@(posedge clk) disable iff (!rst_b)
    (state == ST_CMD && cur_code == CODE_COLD) |=> cold_restart ##1 !cold_restart
      && (state == ST_LOAD) && (rd_base == RST_RD_BASE)
    ) else $error("cold restart not performed");

  chk_page_wrap: assert property (@(posedge clk) disable iff (!rst_b)
    (state == ST_NEXT && wr_code >= wr_pages) |=> (wr_code == CODE_FIRST)
    ) else $error("write page did not wrap");

  chk_other_code: assert property (@(posedge clk) disable iff (!rst_b)
    (new_blk && !is_data && !is_ctl && out_img[0] != CODE_NONE) |=> (state == ST_NEXT)
      ##1 (state == ST_LOAD)
    ) else $error("unknown code not ignored");
endmodule

// ==== hw/word_store.sv ====
// Flip-flop word store with one write port and two combinational read ports.
// Assumes a single clock and a synchronous active-low reset.
`timescale 1ns/1ps
module word_store #(
  parameter int W     = 16,
  parameter int DEPTH = 256,
  parameter int AW    = 8
) (
  // Clock and reset
  input  wire logic          clk,
  input  wire logic          rst_b,
  // Write port
  input  wire logic          we,
  input  wire logic [AW-1:0] waddr,
  input  wire logic [W-1:0]  wdata,
  // Read ports
  input  wire logic [AW-1:0] raddr_a,
  output logic      [W-1:0]  rdata_a,
  input  wire logic [AW-1:0] raddr_b,
  output logic      [W-1:0]  rdata_b
);
  logic [W-1:0] mem [DEPTH];

  always_ff @(posedge clk)
  begin
    if (!rst_b)
    begin
      for (int i = 0; i < DEPTH; i++)
        mem[i] <= '0;
    end
    else if (we)
      mem[waddr] <= wdata;
  end

  assign rdata_a = mem[raddr_a];
  assign rdata_b = mem[raddr_b];
endmodule

// ==== inc/paging_pkg.sv ====
// Constants, codes, register offsets and states of the backplane paging port.
// Assumes a 16-bit word database and a 32-bit APB register bus.
package paging_pkg;
  // ==========================================================================
  // Image and page geometry
  localparam int IN_WORDS   = 8;
  localparam int OUT_WORDS  = 7;
  localparam int PAGE_WORDS = 6;
  localparam int DB_DEPTH   = 256;
  localparam int DB_AW      = 8;
  // ==========================================================================
  // Block identification codes
  localparam logic [15:0] CODE_NONE     = 16'h0000;
  localparam logic [15:0] CODE_FIRST    = 16'h0001;
  localparam logic [15:0] CODE_DATA_MAX = 16'd666;
  localparam logic [15:0] CODE_EV_LO    = 16'd1000;
  localparam logic [15:0] CODE_EV_HI    = 16'd1255;
  localparam logic [15:0] CODE_Q_BASE   = 16'd2000;
  localparam logic [15:0] CODE_Q_LO     = 16'd2001;
  localparam logic [15:0] CODE_Q_HI     = 16'd2006;
  localparam logic [15:0] CODE_WARM     = 16'd9998;
  localparam logic [15:0] CODE_COLD     = 16'd9999;
  // ==========================================================================
  // Register byte offsets
  localparam logic [7:0] OFS_RD_BASE  = 8'h00;
  localparam logic [7:0] OFS_WR_BASE  = 8'h04;
  localparam logic [7:0] OFS_RD_COUNT = 8'h08;
  localparam logic [7:0] OFS_WR_COUNT = 8'h0C;
  localparam logic [7:0] OFS_CODES    = 8'h10;
  localparam logic [7:0] OFS_LAST     = 8'h14;
  localparam logic [7:0] OFS_PAGES    = 8'h18;
  localparam logic [7:0] OFS_DB_ADDR  = 8'h1C;
  localparam logic [7:0] OFS_DB_DATA  = 8'h20;
  // ==========================================================================
  // Values after reset
  localparam logic [15:0] RST_RD_BASE  = 16'h0080;
  localparam logic [15:0] RST_WR_BASE  = 16'h0000;
  localparam logic [15:0] RST_RD_COUNT = 16'h0060;
  localparam logic [15:0] RST_WR_COUNT = 16'h0060;
  // ==========================================================================
  // Paging states, Gray coded along the normal path from ST_LOAD through ST_NEXT
  typedef enum logic [2:0] {
    ST_LOAD  = 3'b000,
    ST_TRIG  = 3'b001,
    ST_HEAD  = 3'b011,
    ST_WAIT  = 3'b010,
    ST_STORE = 3'b110,
    ST_NEXT  = 3'b111,
    ST_CMD   = 3'b101
  } page_state_e;
endpackage

// ==== tb/proc_model.sv ====
// Behavioural processor end of the paging exchange, with its data files.
// Assumes the port's images, one clock and an active-low reset.
`timescale 1ns/1ps
module proc_model
  import paging_pkg::*;
(
  // Clock and reset
  input  wire logic                        clk,
  input  wire logic                        rst_b,
  // Images
  input  wire logic [IN_WORDS-1:0][15:0]   in_img,
  output logic      [OUT_WORDS-1:0][15:0]  out_img,
  // Control blocks asked for by the bench
  input  wire logic                        ctrl_req,
  input  wire logic [15:0]                 ctrl_code,
  input  wire logic [PAGE_WORDS-1:0][15:0] ctrl_data,
  output logic                             ctrl_ack
);
  logic [15:0] wfile [0:4095];
  logic [15:0] rfile [0:4095];
  logic [15:0] last_write;
  logic [15:0] req_code;
  logic [15:0] out_code;
  logic [15:0] resp_w2;
  int          phase;
  int          dly;
  int          nblk;
  int          nresp;

  // A control block goes out only while word 0 is not one, so that a restart,
  // which brings the write code back to one, is seen as a new block.
  always @(posedge clk)
  begin
    ctrl_ack <= 1'b0;
    if (!rst_b)
    begin
      last_write <= CODE_NONE;
      out_img    <= '0;
      phase      <= 0;
      nblk       <= 0;
      nresp      <= 0;
    end
    else if (phase == 0 && in_img[0] != last_write)
    begin
      last_write <= in_img[0];
      req_code   <= in_img[1];
      dly        <= $urandom_range(3);
      phase      <= 1;
      if (in_img[0] != CODE_NONE && in_img[0] <= CODE_DATA_MAX)
      begin
        for (int i = 0; i < PAGE_WORDS; i++)
          wfile[(in_img[0] - 1) * 6 + i] <= in_img[2 + i];
        nblk <= nblk + 1;
      end
      else
      begin
        resp_w2 <= in_img[2];
        nresp   <= nresp + 1;
      end
    end
    else if (phase == 1 && dly > 0)
      dly <= dly - 1;
    else if (phase == 1)
    begin
      phase <= 2;
      if (ctrl_req && last_write != CODE_FIRST)
      begin
        out_img[6:1] <= ctrl_data;
        out_code     <= ctrl_code;
        ctrl_ack     <= 1'b1;
      end
      else
      begin
        out_code <= req_code;
        for (int i = 0; i < PAGE_WORDS; i++)
          out_img[1 + i] <= rfile[(req_code - 1) * 6 + i];
      end
    end
    else if (phase == 2)
    begin
      out_img[0] <= out_code;
      // A zero code carries nothing, so the requested read page follows at once.
      phase      <= (out_code == CODE_NONE) ? 1 : 0;
    end
  end
endmodule

// ==== tb/tb_top.sv ====
// Self-checking bench for the paging port against the processor model.
// Assumes the package offsets and the hand-over timing of the port.
`timescale 1ns/1ps
module tb_top
  import paging_pkg::*;
;
  logic                        clk, rst_b, psel, penable, pwrite, pready, pslverr, err;
  logic                        ev_valid, q_valid, cold_restart, ctrl_req, ctrl_ack;
  logic [7:0]                  paddr, ev_slave, ev_s_seen, s;
  logic [31:0]                 pwdata, prdata, rd;
  logic [IN_WORDS-1:0][15:0]   in_img;
  logic [OUT_WORDS-1:0][15:0]  out_img;
  logic [3:0]                  cmd_free;
  logic [2:0]                  q_count, q_seen;
  logic [PAGE_WORDS-1:0][15:0] cmd_word, payload;
  logic [15:0]                 ctrl_code;
  logic [15:0]                 dbw [0:11];
  logic [15:0]                 bad [0:4] = '{16'd700, 16'd999, 16'd1256, 16'd2007, 16'h0000};
  int                          error_cnt, total_checks, ev_n, q_n, cold_n, n0, r0, f, c0;

  paging_port i_dut (.clk, .rst_b, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .in_img, .out_img, .cmd_free, .ev_valid, .ev_slave, .q_valid,
    .q_count, .cmd_word, .cold_restart);
  proc_model i_proc (.clk, .rst_b, .in_img, .out_img, .ctrl_req, .ctrl_code,
    .ctrl_data(payload), .ctrl_ack);

  initial
  begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  always @(posedge clk)
  begin
    ev_n   <= ev_n + (ev_valid === 1'b1);
    q_n    <= q_n + (q_valid === 1'b1);
    cold_n <= cold_n + (cold_restart === 1'b1);
    if (q_valid === 1'b1)
      q_seen <= q_count;
    if (ev_valid === 1'b1)
      ev_s_seen <= ev_slave;
  end

  // ==========================================================================
  // Checking and bus tasks
  function automatic int exp_q(input int n, input int fr);
    return (fr < n) ? fr : n;
  endfunction

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("Error at %0t ns: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic results();
    if (error_cnt == 0 && total_checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  task automatic hang();
    error_cnt++;
    $display("Error at %0t ns: wait ran out", $time);
    results();
  endtask

  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge clk);
    psel   <= 1'b1;
    pwrite <= w;
    paddr  <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    n = 0;
    do
    begin
      @(posedge clk);
      n++;
    end
    while (pready !== 1'b1 && n < 50);
    rd = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    if (pready !== 1'b1)
      hang();
  endtask

  task automatic send(input logic [15:0] c, input int fr);
    int n;
    r0 = i_proc.nresp;
    @(posedge clk);
    payload   <= {$urandom, $urandom, $urandom};
    ctrl_code <= c;
    cmd_free  <= 4'(fr);
    ctrl_req  <= 1'b1;
    n = 0;
    do
    begin
      @(posedge clk);
      n++;
    end
    while (ctrl_ack !== 1'b1 && n < 3000);
    ctrl_req <= 1'b0;
    n0 = i_proc.nblk;
    if (ctrl_ack !== 1'b1)
      hang();
  endtask

  task automatic wait_prog(input int k, input bit resp);
    int n;
    n = 0;
    while ((resp ? i_proc.nresp == r0 : i_proc.nblk < n0 + k) && n < 3000)
    begin
      @(posedge clk);
      n++;
    end
    if (n >= 3000)
      hang();
  endtask

  // ==========================================================================
  // Main sequence
  initial
  begin
    {rst_b, psel, penable, pwrite, ctrl_req} = '0;
    paddr = '0;
    pwdata = '0;
    cmd_free = '0;
    ctrl_code = '0;
    payload = '0;
    void'($urandom(4));
    for (int i = 0; i < 12; i++)
    begin
      dbw[i] = 16'($urandom);
      i_proc.rfile[i] = 16'($urandom);
    end
    repeat (8) @(posedge clk);
    rst_b <= 1'b1;
    apb(0, OFS_CODES, 0);
    chk(rd, 32'h0001_0001);
    apb(0, OFS_LAST, 0);
    chk(rd, 0);
    apb(0, OFS_RD_BASE, 0);
    chk(rd, RST_RD_BASE);
    apb(0, OFS_RD_COUNT, 0);
    chk(rd, RST_RD_COUNT);
    apb(0, 8'h24, 0);
    chk(err, 1);
    apb(1, OFS_WR_BASE, 32'h10);
    apb(1, OFS_RD_BASE, 32'h40);
    apb(1, OFS_WR_COUNT, 32'hC);
    apb(1, OFS_RD_COUNT, 32'hC);
    for (int i = 0; i < 12; i++)
    begin
      apb(1, OFS_DB_ADDR, 32'h10 + i);
      apb(1, OFS_DB_DATA, dbw[i]);
    end
    send(CODE_WARM, 1);
    wait_prog(5, 0);
    for (int i = 0; i < 12; i++)
      chk(i_proc.wfile[i], dbw[i]);
    for (int i = 0; i < 12; i++)
    begin
      apb(1, OFS_DB_ADDR, 32'h40 + i);
      apb(0, OFS_DB_DATA, 0);
      chk(rd, i_proc.rfile[i]);
    end
    apb(0, OFS_CODES, 0);
    chk(rd[15:0] <= 2 && rd[31:16] <= 2, 1);
    for (int k = 0; k < 4; k++)
    begin
      s = (k == 0) ? 8'hFF : 8'($urandom);
      f = (k == 1) ? 0 : $urandom_range(15, 1);
      send(CODE_EV_LO + s, f);
      wait_prog(0, 1);
      chk(i_proc.resp_w2, f != 0);
      chk(cmd_word === payload, 1);
      if (f != 0)
        chk(ev_s_seen, s);
    end
    for (int k = 1; k <= 6; k++)
    begin
      f = $urandom_range(15);
      c0 = q_n;
      send(16'(CODE_Q_BASE + k), f);
      wait_prog(0, 1);
      chk(i_proc.resp_w2, exp_q(k, f));
      chk(q_n - c0, exp_q(k, f) != 0);
      if (exp_q(k, f) != 0)
        chk(q_seen, exp_q(k, f));
    end
    for (int k = 0; k < 5; k++)
    begin
      c0 = ev_n + q_n;
      send(bad[k], 1);
      wait_prog(2, 0);
      chk(i_proc.nresp, r0);
      chk(ev_n + q_n, c0);
    end
    c0 = cold_n;
    send(CODE_COLD, 1);
    wait_prog(2, 0);
    chk(cold_n - c0, 1);
    apb(0, OFS_WR_COUNT, 0);
    chk(rd, RST_WR_COUNT);
    results();
  end
endmodule
